/* File: hbc_pkg.sv */
package hbc_pkg;

  // register offsets in configuration space (byte addresses)
  localparam logic [7:0] HBC_OFF_DEV_IDENT = 8'h02;
  localparam logic [7:0] HBC_OFF_COMMAND = 8'h04;
  localparam logic [7:0] HBC_OFF_STATUS = 8'h06;

  // reset values
  localparam logic [15:0] HBC_CMD_RESET = 16'h0006;
  localparam logic [15:0] HBC_STS_RESET = 16'h0090;

  // hardwired bits: one where a bit reads one, all others zero
  localparam logic [15:0] HBC_CMD_FIXED = 16'h0006;
  localparam logic [15:0] HBC_STS_FIXED = 16'h0090;

  // command field positions
  localparam int HBC_CMD_SYSERR_EN = 8;
  localparam int HBC_CMD_B2B = 9;
  localparam int HBC_CMD_INITIATOR = 2;
  localparam int HBC_CMD_MEMORY = 1;

  // status field positions
  localparam int HBC_STS_SYSERR_SENT = 14;
  localparam int HBC_STS_MASTER_ABORT = 13;
  localparam int HBC_STS_TARGET_ABORT = 12;
  localparam int HBC_STS_B2B_CAPABLE = 7;
  localparam int HBC_STS_CAP_LIST = 4;

  // configuration access, one 16-bit half-word per request
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } hbc_cfg_req_t;

  // answer to a configuration access
  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } hbc_cfg_rsp_t;

  // error events from the hub interface side of function 0
  typedef struct packed {
    logic err_cond;
    logic master_abort;
    logic target_abort;
  } hbc_evt_t;

endpackage

/* File: hbc_host_bridge_cfg.sv */
module hbc_host_bridge_cfg #(
  // arbitrary neutral identification value
  parameter logic [15:0] DEV_IDENT = 16'h5a5a
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // configuration access
  input hbc_pkg::hbc_cfg_req_t cfg_req_i,
  output hbc_pkg::hbc_cfg_rsp_t cfg_rsp_o,
  // function 0 error events
  input hbc_pkg::hbc_evt_t evt_i,
  // hub interface system-error message request
  output logic syserr_msg_o,
  // current messaging enable for other logic
  output logic syserr_msg_enable_o
);
  import hbc_pkg::*;

  logic syserr_msg_enable_reg;
  logic syserr_msg_enable_next;
  logic [2:0] flags_reg; // {sent, master abort, target abort}
  logic [2:0] flags_next;
  logic msg_reg;
  logic msg_next;
  hbc_cfg_rsp_t rsp_reg;
  hbc_cfg_rsp_t rsp_next;
  logic [15:0] cmd_view;
  logic [15:0] sts_view;
  logic wr_cmd_hi;
  logic wr_sts_hi;
  logic send_msg;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;

  // half-word select on even offsets
  function automatic logic hits(input logic [7:0] a, input logic [7:0] off);
    return a[7:1] == off[7:1];
  endfunction

  // read views: fixed bits from constants, live bits from flops
  always_comb begin
    cmd_view = HBC_CMD_FIXED;
    cmd_view[HBC_CMD_SYSERR_EN] = syserr_msg_enable_reg;
    sts_view = HBC_STS_FIXED;
    sts_view[HBC_STS_SYSERR_SENT] = flags_reg[2];
    sts_view[HBC_STS_MASTER_ABORT] = flags_reg[1];
    sts_view[HBC_STS_TARGET_ABORT] = flags_reg[0];
  end

  // write decode, high byte lane holds every writable bit
  always_comb begin
    wr_cmd_hi = cfg_req_i.valid && cfg_req_i.write && cfg_req_i.be[1]
                && hits(cfg_req_i.addr, HBC_OFF_COMMAND);
    wr_sts_hi = cfg_req_i.valid && cfg_req_i.write && cfg_req_i.be[1]
                && hits(cfg_req_i.addr, HBC_OFF_STATUS);
  end

  // command register next value, only the enable is writable
  always_comb begin
    syserr_msg_enable_next = syserr_msg_enable_reg;
    if (wr_cmd_hi) begin
      syserr_msg_enable_next = cfg_req_i.wdata[HBC_CMD_SYSERR_EN];
    end
  end

  // message generation for function 0 conditions only
  always_comb begin
    send_msg = evt_i.err_cond && syserr_msg_enable_reg;
    msg_next = send_msg;
  end

  // sticky flags: set wins over a same-cycle clear
  always_comb begin
    flag_set = {send_msg, evt_i.master_abort, evt_i.target_abort};
    flag_clr = 3'h0;
    if (wr_sts_hi) begin
      flag_clr = {cfg_req_i.wdata[HBC_STS_SYSERR_SENT],
                  cfg_req_i.wdata[HBC_STS_MASTER_ABORT],
                  cfg_req_i.wdata[HBC_STS_TARGET_ABORT]};
    end
    flags_next = (flags_reg & ~flag_clr) | flag_set;
  end

  // read answer one cycle after the request, unmapped reads zero
  always_comb begin
    rsp_next = '0;
    if (cfg_req_i.valid) begin
      rsp_next.ack = 1'b1;
      if (!cfg_req_i.write) begin
        if (hits(cfg_req_i.addr, HBC_OFF_DEV_IDENT)) begin
          rsp_next.rdata = DEV_IDENT;
        end else if (hits(cfg_req_i.addr, HBC_OFF_COMMAND)) begin
          rsp_next.rdata = cmd_view;
        end else if (hits(cfg_req_i.addr, HBC_OFF_STATUS)) begin
          rsp_next.rdata = sts_view;
        end
      end
    end
  end

  // state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      syserr_msg_enable_reg <= HBC_CMD_RESET[HBC_CMD_SYSERR_EN];
      flags_reg <= {HBC_STS_RESET[HBC_STS_SYSERR_SENT],
                    HBC_STS_RESET[HBC_STS_MASTER_ABORT],
                    HBC_STS_RESET[HBC_STS_TARGET_ABORT]};
      msg_reg <= 1'b0;
      rsp_reg <= '0;
    end else begin
      syserr_msg_enable_reg <= syserr_msg_enable_next;
      flags_reg <= flags_next;
      msg_reg <= msg_next;
      rsp_reg <= rsp_next;
    end
  end

  // outputs straight from flops
  assign cfg_rsp_o = rsp_reg;
  assign syserr_msg_o = msg_reg;
  assign syserr_msg_enable_o = syserr_msg_enable_reg;

  // checks
  devid_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_req_i.valid && !cfg_req_i.write && hits(cfg_req_i.addr, HBC_OFF_DEV_IDENT)
    |=> cfg_rsp_o.ack && cfg_rsp_o.rdata == DEV_IDENT)
    else $error("device ident read wrong");

  cmd_reset_a: assert property (@(posedge clk_i)
    rst_i |=> !syserr_msg_enable_o && !syserr_msg_o)
    else $error("command enable not cleared by reset");

  cmd_fixed_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_req_i.valid && !cfg_req_i.write && hits(cfg_req_i.addr, HBC_OFF_COMMAND)
    |=> (cfg_rsp_o.rdata & ~16'h0100) == HBC_CMD_FIXED
        && cfg_rsp_o.rdata[HBC_CMD_SYSERR_EN] == syserr_msg_enable_o)
    else $error("command hardwired bits wrong");

  msg_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    evt_i.err_cond && !syserr_msg_enable_o |=> !syserr_msg_o)
    else $error("message sent while disabled");

  msg_send_a: assert property (@(posedge clk_i) disable iff (rst_i)
    evt_i.err_cond && syserr_msg_enable_o |=> syserr_msg_o && flags_reg[2])
    else $error("enabled error gave no message or flag");

  sts_fixed_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_req_i.valid && !cfg_req_i.write && hits(cfg_req_i.addr, HBC_OFF_STATUS)
    |=> (cfg_rsp_o.rdata & ~16'h7000) == HBC_STS_FIXED)
    else $error("status hardwired bits wrong");

  master_abort_a: assert property (@(posedge clk_i) disable iff (rst_i)
    evt_i.master_abort |=> flags_reg[1])
    else $error("master abort flag not set");

  target_abort_a: assert property (@(posedge clk_i) disable iff (rst_i)
    evt_i.target_abort |=> flags_reg[0])
    else $error("target abort flag not set");

  zero_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_sts_hi && !cfg_req_i.wdata[HBC_STS_TARGET_ABORT] && flags_reg[0] |=> flags_reg[0])
    else $error("writing zero cleared target abort flag");

  one_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_sts_hi && cfg_req_i.wdata[HBC_STS_MASTER_ABORT] && !evt_i.master_abort |=> !flags_reg[1])
    else $error("writing one did not clear flag");

  enable_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr_cmd_hi |=> $stable(syserr_msg_enable_o))
    else $error("enable changed without command write");

  // flag, enable and message behaviour around writes, events and reset, and hardwired command and status bits
  set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_sts_hi && cfg_req_i.wdata[HBC_STS_TARGET_ABORT] && evt_i.target_abort |=> flags_reg[0])
    else $error("clear beat a same-cycle target abort");

  sts_reset_a: assert property (@(posedge clk_i)
    rst_i |=> flags_reg == 3'h0)
    else $error("status flags not cleared by reset");

  enable_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_cmd_hi && cfg_req_i.wdata[HBC_CMD_SYSERR_EN] |=> syserr_msg_enable_o)
    else $error("enable not set by command write");

  enable_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_cmd_hi && !cfg_req_i.wdata[HBC_CMD_SYSERR_EN] |=> !syserr_msg_enable_o)
    else $error("enable not cleared by command write");

  stray_msg_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !evt_i.err_cond |=> !syserr_msg_o)
    else $error("message without error condition");

  sent_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_sts_hi && cfg_req_i.wdata[HBC_STS_SYSERR_SENT] && !send_msg |=> !flags_reg[2])
    else $error("writing one did not clear sent flag");

  target_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_sts_hi && cfg_req_i.wdata[HBC_STS_TARGET_ABORT] && !evt_i.target_abort |=> !flags_reg[0])
    else $error("writing one did not clear target abort flag");

  master_mem_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_req_i.valid && !cfg_req_i.write && hits(cfg_req_i.addr, HBC_OFF_COMMAND)
    |=> cfg_rsp_o.rdata[HBC_CMD_INITIATOR] && cfg_rsp_o.rdata[HBC_CMD_MEMORY]
        && !cfg_rsp_o.rdata[HBC_CMD_B2B])
    else $error("command initiator, memory or b2b bit wrong");

  cap_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_req_i.valid && !cfg_req_i.write && hits(cfg_req_i.addr, HBC_OFF_STATUS)
    |=> cfg_rsp_o.rdata[HBC_STS_B2B_CAPABLE] && cfg_rsp_o.rdata[HBC_STS_CAP_LIST])
    else $error("status capability bits wrong");

endmodule

/* File: hbc_hub_partner.sv */
module hbc_hub_partner (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // system-error message request from the bridge
  input wire logic msg_i,
  // number of message packets accepted so far
  output int msg_count_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // accept and count every message packet, no back-pressure
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      msg_count_o <= 0;
    end else if (msg_i) begin
      msg_count_o <= msg_count_o + 1;
    end
  end
endmodule

/* File: hbc_host_bridge_cfg_test.sv */
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module hbc_host_bridge_cfg_test;
  timeunit 1ns;
  timeprecision 1ps;
  import hbc_pkg::*;
  localparam logic [15:0] IDENT = 16'h3c3c;  // arbitrary value
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  hbc_cfg_req_t req = '0;
  hbc_cfg_rsp_t rsp;
  hbc_evt_t evt = '0;
  logic msg;
  logic msg_en;
  int n_fail = 0;
  int n_compared = 0;
  int msg_count;

  hbc_host_bridge_cfg #(.DEV_IDENT(IDENT)) hbc_host_bridge_cfg_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cfg_req_i(req), .cfg_rsp_o(rsp), .evt_i(evt),
    .syserr_msg_o(msg), .syserr_msg_enable_o(msg_en));
  hbc_hub_partner hbc_hub_partner_inst (
    .clk_i(clk_i), .rst_i(rst_i), .msg_i(msg), .msg_count_o(msg_count));

  // 50 ns clock
  initial begin
    forever #25 clk_i = ~clk_i;
  end

  // one request after an idle cycle, answer checked a cycle later
  task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d,
                        input logic [15:0] exp);
    @(negedge clk_i);
    req = '{valid: 1'b1, write: wr, addr: a, be: 2'b11, wdata: d};
    @(negedge clk_i);
    req.valid = 1'b0;
    `CHK("ack", 1'b1, rsp.ack)
    if (!wr) `CHK("rdata", exp, rsp.rdata)
  endtask

  // one-cycle error event pulse
  task automatic fire(input hbc_evt_t e);
    @(negedge clk_i);
    evt = e;
    @(negedge clk_i);
    evt = '0;
  endtask

  // verdict and end of run
  task automatic complete_run();
    if (n_fail == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    `CHK("enable", 1'b0, msg_en)
    access(0, HBC_OFF_DEV_IDENT, '0, IDENT);
    access(0, HBC_OFF_COMMAND, '0, HBC_CMD_RESET);
    access(0, HBC_OFF_STATUS, '0, HBC_STS_RESET);
    access(0, 8'h08, '0, 16'h0000);
    access(1, HBC_OFF_DEV_IDENT, 16'hffff, '0);
    access(0, HBC_OFF_DEV_IDENT, '0, IDENT);
    access(1, HBC_OFF_COMMAND, 16'hffff, '0);
    access(0, HBC_OFF_COMMAND, '0, 16'h0106);
    `CHK("enable", 1'b1, msg_en)
    fire(3'b111);
    `CHK("message", 1'b1, msg)
    @(negedge clk_i);
    `CHK("message", 1'b0, msg)
    `CHK("messages", 1, msg_count)
    access(0, HBC_OFF_STATUS, '0, 16'h7090);
    access(1, HBC_OFF_STATUS, 16'h2000, '0);
    access(0, HBC_OFF_STATUS, '0, 16'h5090);
    access(1, HBC_OFF_STATUS, 16'hffff, '0);
    access(0, HBC_OFF_STATUS, '0, 16'h0090);
    access(1, HBC_OFF_COMMAND, 16'h0000, '0);
    fire(3'b100);
    `CHK("message", 1'b0, msg)
    `CHK("messages", 1, msg_count)
    access(0, HBC_OFF_STATUS, '0, 16'h0090);
    // clear and abort in one cycle: the abort must survive
    fork
      access(1, HBC_OFF_STATUS, 16'hffff, '0);
      fire(3'b001);
    join
    access(0, HBC_OFF_STATUS, '0, 16'h1090);
    // set state, then reset in mid-run
    access(1, HBC_OFF_COMMAND, 16'h0100, '0);
    fire(3'b111);
    @(negedge clk_i);
    `CHK("messages", 2, msg_count)
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    `CHK("enable", 1'b0, msg_en)
    access(0, HBC_OFF_COMMAND, '0, HBC_CMD_RESET);
    access(0, HBC_OFF_STATUS, '0, HBC_STS_RESET);
    complete_run();
  end

  // watchdog against a hang
  initial begin
    #(200 * 50);
    n_fail++;
    complete_run();
  end
endmodule
